// *** design/lss_blink_gen.sv ***
// Blink divider: toggles a phase bit once per selected period
module lss_blink_gen #(
   parameter int P0 = 1000000,
   parameter int P1 = 2000000,
   parameter int P2 = 4000000,
   parameter int P3 = 10000000
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [1:0] rate_in,
   output logic phase_out
);
   import lss_pkg::*;
   logic [23:0] cnt_r;
   logic [23:0] lim;
   initial begin
      if (P0 < 1 || P3 >= (1 << 24)) $error("lss_blink_gen: bad period");
   end
   // Period select; a rate change applies to the running count at once, wrapping on the next edge if already past the new limit
   always_comb begin
      case (rate_in)
         2'h0: lim = 24'(P0 - 1);
         2'h1: lim = 24'(P1 - 1);
         2'h2: lim = 24'(P2 - 1);
         default: lim = 24'(P3 - 1);
      endcase
   end
   // Count the period, flip phase on wrap
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt_r <= 24'h0;
         phase_out <= 1'b0;
      end else if (cnt_r >= lim) begin
         cnt_r <= 24'h0;
         phase_out <= ~phase_out;
      end else begin
         cnt_r <= cnt_r + 24'h1;
      end
   end
endmodule

// *** design/lss_light_mux.sv ***
// One light: decodes a source code into a lit/dark level
module lss_light_mux (
   input wire lss_pkg::lss_src_t src_in,
   input wire lss_pkg::lss_evt_t evt_in,
   input wire logic lost_in,
   input wire logic prbs_in,
   input wire logic phase_in,
   output logic lit_out
);
   import lss_pkg::*;
   logic blink_act;
   logic blink_tx;
   logic blink_rx;
   // Activity blinks at the selected period, otherwise steady on
   assign blink_act = (evt_in.tx_act | evt_in.rx_act) ? phase_in : 1'b1;
   assign blink_tx = evt_in.tx_act ? phase_in : 1'b1;
   assign blink_rx = evt_in.rx_act ? phase_in : 1'b1;
   // Shared decode table for all three lights
   always_comb begin
      case (src_in)
         LSS_SRC_LINK: lit_out = evt_in.link_good;
         LSS_SRC_LINK_ACT: lit_out = evt_in.link_good & blink_act;
         LSS_SRC_LINK_TX: lit_out = evt_in.link_good & blink_tx;
         LSS_SRC_LINK_RX: lit_out = evt_in.link_good & blink_rx;
         LSS_SRC_LINK_MASTER: begin
            lit_out = evt_in.link_good & evt_in.is_master;
         end
         LSS_SRC_LINK_SLAVE: begin
            lit_out = evt_in.link_good & ~evt_in.is_master;
         end
         LSS_SRC_ACT: lit_out = (evt_in.tx_act | evt_in.rx_act) & phase_in;
         LSS_SRC_LINK_LOST: lit_out = lost_in;
         LSS_SRC_PRBS_ERR: lit_out = prbs_in;
         default: lit_out = 1'b0;
      endcase
   end
endmodule

// *** design/lss_pkg.sv ***
// Package: register map, field layout, codes and timing for the light selector
// Summary of operation
// - Blink field bits 13:12, reset 10, picks 50, 100, 200 or 500 ms period.
// - Light zero source field bits 3:0, reset 0000 means link good.
// - Code 0001 is link good with any activity; light one resets to it.
// - Code 0010 is link good with transmit activity only.
// - Link good with receive, and link good as master; printed code ambiguous.
// - Code 0101 is link good while acting as slave.
// - Code 0110 is any activity regardless of link; light two resets to it.
// - Light one and two fields decode the same table as light zero.
// - Code 1001 lights on link loss until basic status register 0x1 is read.
// - Code 1010 lights after any PRBS error until the error counter clears.
// - Termination code bits 4:1, reset 1000 (58 ohm); larger means lower.
// - Termination code drives the receive data, clock, error and valid pins.
// - One common termination setting for all pins, no per-pin control.
package lss_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [11:0] LSS_IDX_LIGHT_CFG = 12'h460;
   localparam logic [11:0] LSS_IDX_TERM_CTRL = 12'h461;
   localparam logic [13:0] LSS_ADDR_LIGHT_CFG = {LSS_IDX_LIGHT_CFG, 2'h0};
   localparam logic [13:0] LSS_ADDR_TERM_CTRL = {LSS_IDX_TERM_CTRL, 2'h0};
   // Reset values of the two 16-bit registers
   localparam logic [15:0] LSS_LIGHT_CFG_RST = 16'h2610;
   localparam logic [15:0] LSS_TERM_CTRL_RST = 16'h0410;
   // Field positions
   localparam int LSS_SRC0_LSB = 0;
   localparam int LSS_SRC_W = 4;
   localparam int LSS_BLINK_LSB = 12;
   localparam int LSS_TERM_LSB = 1;
   // Source codes
   localparam logic [3:0] LSS_SRC_LINK = 4'h0;
   localparam logic [3:0] LSS_SRC_LINK_ACT = 4'h1;
   localparam logic [3:0] LSS_SRC_LINK_TX = 4'h2;
   localparam logic [3:0] LSS_SRC_LINK_RX = 4'h3;
   localparam logic [3:0] LSS_SRC_LINK_MASTER = 4'h4;
   localparam logic [3:0] LSS_SRC_LINK_SLAVE = 4'h5;
   localparam logic [3:0] LSS_SRC_ACT = 4'h6;
   localparam logic [3:0] LSS_SRC_LINK_LOST = 4'h9;
   localparam logic [3:0] LSS_SRC_PRBS_ERR = 4'ha;
   // Timing: clock 20 MHz, blink periods in ms
   localparam int LSS_CLK_HZ = 20000000;
   localparam int LSS_BLINK0_MS = 50;
   localparam int LSS_BLINK1_MS = 100;
   localparam int LSS_BLINK2_MS = 200;
   localparam int LSS_BLINK3_MS = 500;
   localparam int LSS_CYC_PER_MS = LSS_CLK_HZ / 1000;
   // Raw events from the surrounding device
   typedef struct packed {
      logic link_good;
      logic tx_act;
      logic rx_act;
      logic is_master;
      logic status_read;
      logic prbs_err;
      logic prbs_clr;
   } lss_evt_t;
   // Each light's source code
   typedef logic [3:0] lss_src_t;
endpackage

// *** design/lss_top.sv ***
// Top: APB register file, latched indications and light outputs
module lss_top #(
   parameter int BLINK0_CYC = lss_pkg::LSS_BLINK0_MS * lss_pkg::LSS_CYC_PER_MS,
   parameter int BLINK1_CYC = lss_pkg::LSS_BLINK1_MS * lss_pkg::LSS_CYC_PER_MS,
   parameter int BLINK2_CYC = lss_pkg::LSS_BLINK2_MS * lss_pkg::LSS_CYC_PER_MS,
   parameter int BLINK3_CYC = lss_pkg::LSS_BLINK3_MS * lss_pkg::LSS_CYC_PER_MS
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [15:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire lss_pkg::lss_evt_t evt_in,
   output logic status_light_zero_out,
   output logic status_light_one_out,
   output logic status_light_two_out,
   output logic [3:0] mac_side_interface_term_out
);
   import lss_pkg::*;
   logic [15:0] cfg_r;
   logic [15:0] term_r;
   logic lost_r;
   logic prbs_r;
   logic link_d_r;
   logic phase;
   logic [2:0] lit;
   logic acc;
   logic hit_cfg;
   logic hit_term;
   logic [15:0] rd_nxt;
   lss_src_t src [3];

   // A period under one cycle would leave the divider stuck; refuse it
   initial begin
      if (BLINK0_CYC < 1 || BLINK1_CYC < 1 || BLINK2_CYC < 1 ||
          BLINK3_CYC < 1) begin
         $error("lss_top: blink period below one cycle");
      end
   end

   // Access phase of an APB transfer; the slave answers with no wait
   assign acc = psel_in & penable_in;
   assign hit_cfg = (paddr_in[15:14] == 2'h0) &&
                    (paddr_in[13:0] == LSS_ADDR_LIGHT_CFG);
   assign hit_term = (paddr_in[15:14] == 2'h0) &&
                     (paddr_in[13:0] == LSS_ADDR_TERM_CTRL);

   // Configuration register: sources and blink rate
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg_r <= LSS_LIGHT_CFG_RST;
      end else if (acc && pwrite_in && hit_cfg) begin
         if (pstrb_in[0]) cfg_r[7:0] <= pwdata_in[7:0];
         if (pstrb_in[1]) cfg_r[15:8] <= pwdata_in[15:8];
      end
   end

   // Termination register: one code for every receive pin
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         term_r <= LSS_TERM_CTRL_RST;
      end else if (acc && pwrite_in && hit_term) begin
         if (pstrb_in[0]) term_r[7:0] <= pwdata_in[7:0];
         if (pstrb_in[1]) term_r[15:8] <= pwdata_in[15:8];
      end
   end

   // Read mux; unmapped addresses read zero and flag an error
   always_comb begin
      rd_nxt = 16'h0;
      if (hit_cfg) rd_nxt = cfg_r;
      else if (hit_term) rd_nxt = term_r;
   end

   // APB answer registered from the setup cycle, presented in the access cycle
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prdata_out <= 32'h0;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end else begin
         pready_out <= psel_in & ~penable_in;
         pslverr_out <= psel_in & ~penable_in & ~(hit_cfg | hit_term);
         prdata_out <= (psel_in & ~penable_in & ~pwrite_in) ?
                       {16'h0, rd_nxt} : 32'h0;
      end
   end

   // Link-lost latch: set on link falling, cleared by the status read;
   // a loss in the same cycle as the read wins
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         link_d_r <= 1'b0;
         lost_r <= 1'b0;
      end else begin
         link_d_r <= evt_in.link_good;
         if (link_d_r && !evt_in.link_good) lost_r <= 1'b1;
         else if (evt_in.status_read) lost_r <= 1'b0;
      end
   end

   // PRBS error latch: a single error holds until the counter clears
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prbs_r <= 1'b0;
      end else if (evt_in.prbs_err) begin
         prbs_r <= 1'b1;
      end else if (evt_in.prbs_clr) begin
         prbs_r <= 1'b0;
      end
   end

   lss_blink_gen #(
      .P0(BLINK0_CYC),
      .P1(BLINK1_CYC),
      .P2(BLINK2_CYC),
      .P3(BLINK3_CYC)
   ) u_blink (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .rate_in(cfg_r[LSS_BLINK_LSB +: 2]),
      .phase_out(phase)
   );

   // One decoder per light, all reading the same table
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_light
         assign src[gi] = cfg_r[LSS_SRC0_LSB + gi*LSS_SRC_W +: LSS_SRC_W];
         lss_light_mux u_mux (
            .src_in(src[gi]),
            .evt_in(evt_in),
            .lost_in(lost_r),
            .prbs_in(prbs_r),
            .phase_in(phase),
            .lit_out(lit[gi])
         );
      end
   endgenerate

   // Outputs come from flip-flops; one code fans out to all pins
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         status_light_zero_out <= 1'b0;
         status_light_one_out <= 1'b0;
         status_light_two_out <= 1'b0;
         mac_side_interface_term_out <= LSS_TERM_CTRL_RST[4:1];
      end else begin
         status_light_zero_out <= lit[0];
         status_light_one_out <= lit[1];
         status_light_two_out <= lit[2];
         mac_side_interface_term_out <= term_r[LSS_TERM_LSB +: 4];
      end
   end

   // Checks
   sequence s_link_drop;
      link_d_r && !evt_in.link_good;
   endsequence
   lost_sets_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_link_drop |=> lost_r) else $error("lost not set");
   lost_holds_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      lost_r && !evt_in.status_read |=> lost_r)
      else $error("lost dropped early");
   prbs_holds_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      prbs_r && !evt_in.prbs_clr |=> prbs_r)
      else $error("prbs dropped early");
   prbs_sets_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      evt_in.prbs_err |=> prbs_r) else $error("prbs not set");
   link_light_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[0] == LSS_SRC_LINK |=>
      status_light_zero_out == $past(evt_in.link_good))
      else $error("light zero not link");
   reserved_dark_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[1] == 4'h7 || src[1] == 4'hf |=> !status_light_one_out)
      else $error("reserved code lit");
   term_follow_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      ##1 mac_side_interface_term_out == $past(term_r[4:1]))
      else $error("term code wrong");
   slave_light_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[2] == LSS_SRC_LINK_SLAVE && evt_in.is_master |=> !status_light_two_out)
      else $error("slave light with master");
   steady_idle_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[1] == LSS_SRC_LINK_ACT && evt_in.link_good && !evt_in.tx_act &&
      !evt_in.rx_act |=> status_light_one_out)
      else $error("idle not steady");

   // Bus phases as seen by the slave
   sequence s_setup;
      psel_in && !penable_in;
   endsequence
   sequence s_cfg_write;
      acc && pwrite_in && hit_cfg && pstrb_in[1:0] == 2'h3;
   endsequence
   sequence s_term_write;
      acc && pwrite_in && hit_term && pstrb_in[1:0] == 2'h3;
   endsequence

   // Answer timing: one pulse, right after the setup cycle
   ready_access_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_setup |=> pready_out) else $error("no ready in access");
   ready_once_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      pready_out |=> !pready_out) else $error("ready held");
   err_unmapped_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_setup ##0 !(hit_cfg || hit_term) |=> pslverr_out)
      else $error("no error on unmapped");
   err_mapped_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_setup ##0 (hit_cfg || hit_term) |=> !pslverr_out)
      else $error("error on mapped");

   // Read data come from the addressed register, writes read as zero
   rd_cfg_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_setup ##0 (!pwrite_in && hit_cfg) |=>
      prdata_out == {16'h0, $past(cfg_r)})
      else $error("cfg read wrong");
   rd_term_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_setup ##0 (!pwrite_in && hit_term) |=>
      prdata_out == {16'h0, $past(term_r)})
      else $error("term read wrong");
   rd_on_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_setup ##0 pwrite_in |=> prdata_out == 32'h0)
      else $error("data on write");

   // Writes land only in the access cycle of a matching address
   cfg_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_cfg_write |=> cfg_r == $past(pwdata_in[15:0]))
      else $error("cfg write lost");
   term_write_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      s_term_write |=> term_r == $past(pwdata_in[15:0]))
      else $error("term write lost");
   cfg_keep_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !(acc && pwrite_in && hit_cfg) |=> cfg_r == $past(cfg_r))
      else $error("cfg changed");
   term_keep_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !(acc && pwrite_in && hit_term) |=> term_r == $past(term_r))
      else $error("term changed");

   // Latches clear only on their own event and never set by themselves
   lost_clear_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      evt_in.status_read && !(link_d_r && !evt_in.link_good) |=> !lost_r)
      else $error("lost not cleared");
   lost_quiet_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !lost_r && !(link_d_r && !evt_in.link_good) |=> !lost_r)
      else $error("lost set alone");
   prbs_clear_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      evt_in.prbs_clr && !evt_in.prbs_err |=> !prbs_r)
      else $error("prbs not cleared");
   prbs_quiet_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      !prbs_r && !evt_in.prbs_err |=> !prbs_r)
      else $error("prbs set alone");

   // Per-code behaviour of the lights, one edge behind the source
   lost_light_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[0] == LSS_SRC_LINK_LOST |=> status_light_zero_out == $past(lost_r))
      else $error("lost light wrong");
   prbs_light_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[1] == LSS_SRC_PRBS_ERR |=> status_light_one_out == $past(prbs_r))
      else $error("prbs light wrong");
   master_light_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[0] == LSS_SRC_LINK_MASTER |=>
      status_light_zero_out == $past(evt_in.link_good && evt_in.is_master))
      else $error("master light wrong");
   tx_steady_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[2] == LSS_SRC_LINK_TX && evt_in.link_good && !evt_in.tx_act
      |=> status_light_two_out)
      else $error("tx light not steady");
   rx_nolink_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[0] == LSS_SRC_LINK_RX && !evt_in.link_good
      |=> !status_light_zero_out)
      else $error("rx light without link");
   act_nolink_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[1] == LSS_SRC_LINK_ACT && !evt_in.link_good
      |=> !status_light_one_out)
      else $error("act light without link");
   act_dark_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[2] == LSS_SRC_ACT && !evt_in.tx_act && !evt_in.rx_act
      |=> !status_light_two_out)
      else $error("idle activity lit");
   act_phase_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[0] == LSS_SRC_ACT && evt_in.tx_act
      |=> status_light_zero_out == $past(phase))
      else $error("activity not blinking");
   reserved_zero_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[0] == 4'h8 || src[0] == 4'hb |=> !status_light_zero_out)
      else $error("reserved code lit");

   // Same code on two lights must give the same level
   same_table_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[0] == src[1] |=> status_light_zero_out == status_light_one_out)
      else $error("lights zero one differ");
   same_table2_a: assert property (@(posedge mclk_in) disable iff (!rst_n_in)
      src[1] == src[2] |=> status_light_one_out == status_light_two_out)
      else $error("lights one two differ");
endmodule

// *** dv/lss_led_model.sv ***
// External status light model: tracks level changes of one light
module lss_led_model (
   input wire logic mclk_in,
   input wire logic clr_in,
   input wire logic light_in,
   output int flips_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic last_r;
   // Count every change of level; a steady light counts nothing
   always @(posedge mclk_in) begin
      last_r <= light_in;
      if (clr_in) begin
         flips_out <= 0;
      end else if (light_in !== last_r) begin
         flips_out <= flips_out + 1;
      end
   end
endmodule

// *** dv/test_lss_top.sv ***
// Testbench for the light selector and termination register block
module test_lss_top;
   import lss_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, clr = 1;
   logic [15:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic pready, pslverr, er, l0, l1, l2;
   logic [3:0] term;
   lss_evt_t evt = '0;
   int bad_count = 0, tests_run = 0, flips;
   lss_top #(.BLINK0_CYC(4), .BLINK1_CYC(6), .BLINK2_CYC(8),
      .BLINK3_CYC(10)) i_dut (.mclk_in(clk), .rst_n_in(rst_n),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
      .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
      .evt_in(evt), .status_light_zero_out(l0),
      .status_light_one_out(l1), .status_light_two_out(l2),
      .mac_side_interface_term_out(term));
   lss_led_model i_led (.mclk_in(clk), .clr_in(clr), .light_in(l0),
      .flips_out(flips));
   initial begin
      forever #25 clk = ~clk;
   end
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; waits for pready under a bounded count
   task automatic apb(input logic wr, input logic [15:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1; pen <= 0; pwr <= wr; paddr <= a; pwdata <= d;
      @(posedge clk);
      pen <= 1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 0; pen <= 0;
      if (n == 16) check(0, 1);
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Reset values, termination field and an unmapped address
   task automatic t_regs;
      apb(0, LSS_ADDR_LIGHT_CFG, 0);
      check(rd, 32'h0000_2610);
      check(er, 1'b0);
      apb(0, LSS_ADDR_TERM_CTRL, 0);
      check(rd, 32'h0000_0410);
      check(term, 4'h8);
      apb(1, LSS_ADDR_TERM_CTRL, 32'h0000_001e);
      wait_cyc(2);
      check(term, 4'hf);
      apb(0, 16'h0100, 0);
      check(er, 1'b1);
      check(rd, 32'h0);
   endtask
   // Every code on all three lights at once, link up and no activity
   task automatic t_codes(input logic master, input logic [15:0] exp);
      for (int c = 0; c < 16; c++) begin
         apb(1, LSS_ADDR_LIGHT_CFG, {20'h00002, {3{c[3:0]}}});
         wait_cyc(3);
         check({l0, l1, l2}, {3{exp[c]}});
      end
   endtask
   // Latched indications: link loss and PRBS errors
   task automatic t_latch;
      apb(1, LSS_ADDR_LIGHT_CFG, 32'h0000_2aa9);
      evt.link_good <= 0;
      wait_cyc(4);
      check(l0, 1);
      evt.status_read <= 1;
      wait_cyc(1);
      evt.status_read <= 0;
      wait_cyc(3);
      check(l0, 0);
      check({l1, l2}, 2'b00);
      evt.prbs_err <= 1;
      wait_cyc(1);
      evt.prbs_err <= 0;
      wait_cyc(20);
      check({l1, l2}, 2'b11);
      evt.prbs_clr <= 1;
      wait_cyc(1);
      evt.prbs_clr <= 0;
      wait_cyc(3);
      check({l1, l2}, 2'b00);
   endtask
   // Blink rate: count toggles of an active light over a fixed window
   task automatic t_blink;
      int p[4] = '{4, 6, 8, 10};
      evt.tx_act <= 1;
      for (int r = 0; r < 4; r++) begin
         apb(1, LSS_ADDR_LIGHT_CFG, {18'h0, r[1:0], 12'h666});
         wait_cyc(12);
         clr <= 0;
         wait_cyc(120);
         check(flips >= 120 / p[r] - 1 &&
               flips <= 120 / p[r] + 1, 1);
         clr <= 1;
      end
      // Link is down here: link-qualified activity codes stay dark
      apb(1, LSS_ADDR_LIGHT_CFG, 32'h0000_2221);
      wait_cyc(3);
      check({l0, l1, l2}, 3'b000);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #(50 * 20000);
      bad_count++;
      results();
   end
   initial begin
      wait_cyc(4);
      rst_n <= 1;
      t_regs();
      evt.link_good <= 1;
      evt.is_master <= 1;
      t_codes(1, 16'h001f);
      evt.is_master <= 0;
      t_codes(0, 16'h002f);
      t_latch();
      t_blink();
      results();
   end
endmodule
